// *** rtl/rcm_monitor.sv ***
// Register checksum monitor: scans user registers and frame memory
`timescale 1ns/100ps
module rcm_monitor
	import rcm_pkg::*;
#(
	parameter int PASS_CYCLES = PASS_CYCLES_DEF,
	parameter int SCAN_BYTES  = SCAN_BYTES_DEF
)
(
	// Clock and reset
	input  wire logic               clk_sys_i,
	input  wire logic               sys_rst_i,
	// Host command port
	input  wire logic               cmd_wr_i,
	input  wire logic               cmd_rd_i,
	input  wire logic [7:0]         cmd_code_i,
	output logic      [7:0]         rd_data_o,
	output logic                    rd_valid_o,
	// Power state
	input  wire logic               sleep_out_i,
	// Byte scan of registers and frame memory
	output logic      [SCAN_AW-1:0] scan_addr_o,
	input  wire logic [7:0]         scan_data_i,
	output logic                    scan_en_o,
	// Status
	output logic      [7:0]         first_pass_sum_o,
	output logic      [7:0]         running_pass_sum_o,
	output logic                    sum_match_flag_o
);
	localparam int STEP_DIV = (PASS_CYCLES / SCAN_BYTES) < 1 ? 1
		: (PASS_CYCLES / SCAN_BYTES);
	localparam logic [SCAN_AW-1:0] LAST_ADDR = SCAN_AW'(SCAN_BYTES - 1);

	rcm_state_t         state_reg;
	logic [SCAN_AW-1:0] addr_reg;
	logic [7:0]         acc_reg;
	logic [7:0]         first_reg;
	logic [7:0]         cont_reg;
	logic               match_reg;
	logic               step;
	logic               pass_end;
	logic [7:0]         sum_next;
	logic               running;

	function automatic logic [7:0] add8(input logic [7:0] a,
		input logic [7:0] b);
		add8 = 8'(a + b);
	endfunction

	assign running  = (state_reg != RCM_IDLE) && sleep_out_i;
	assign sum_next = add8(acc_reg, scan_data_i);
	assign pass_end = step && (addr_reg == LAST_ADDR);

	rcm_step_div #(
		.DIV       (STEP_DIV)
	) u_div (
		.clk_sys_i (clk_sys_i),
		.sys_rst_i (sys_rst_i),
		.restart_i (cmd_wr_i),
		.run_i     (running),
		.step_o    (step)
	);

	// Sequence: a write restarts from the first pass
	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
			state_reg <= RCM_IDLE;
		else if (cmd_wr_i)
			state_reg <= RCM_FIRST;
		else if (pass_end)
			state_reg <= RCM_RUN;
	end

	// Fixed ascending scan order
	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i || cmd_wr_i)
			addr_reg <= '0;
		else if (step)
			addr_reg <= pass_end ? '0 : addr_reg + 1'b1;
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i || cmd_wr_i)
			acc_reg <= SUM_RESET;
		else if (pass_end)
			acc_reg <= SUM_RESET;
		else if (step)
			acc_reg <= sum_next;
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i || cmd_wr_i)
			first_reg <= SUM_RESET;
		else if (pass_end && state_reg == RCM_FIRST)
			first_reg <= sum_next;
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i || cmd_wr_i)
		begin
			cont_reg  <= SUM_RESET;
			match_reg <= 1'b0;
		end
		else if (pass_end && state_reg == RCM_RUN)
		begin
			cont_reg  <= sum_next;
			match_reg <= (sum_next == first_reg);
		end
	end

	// Read commands answer one cycle later
	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
		begin
			rd_data_o  <= SUM_RESET;
			rd_valid_o <= 1'b0;
		end
		else
		begin
			rd_valid_o <= cmd_rd_i;
			if (cmd_rd_i)
			begin
				unique case (cmd_code_i)
					CMD_RD_FIRST: rd_data_o <= first_reg;
					CMD_RD_CONT:  rd_data_o <= cont_reg;
					CMD_RD_DIAG:  rd_data_o <= 8'(match_reg) << DIAG_MATCH_BIT;
					default:      rd_data_o <= SUM_RESET;
				endcase
			end
		end
	end

	assign scan_addr_o        = addr_reg;
	assign scan_en_o          = step;
	assign first_pass_sum_o   = first_reg;
	assign running_pass_sum_o = cont_reg;
	assign sum_match_flag_o   = match_reg;
endmodule

// *** rtl/rcm_pkg.sv ***
// Constants shared by the register checksum monitor
// Overview of operation
// - Two 8-bit results are kept, a first-pass sum and a continuing sum over all user registers and frame memory.
// - Starting a new calculation clears both results to zero.
// - Only a host write to a user register starts a new calculation, never a host read.
// - A host write during a calculation aborts it and restarts summation from the first byte.
// - The first completed sum is stored as the first-pass result and held until a later write clears it for a new first pass.
// - The first-pass result is readable no later than 150 ms after the last host write.
// - After the first pass summing continues and each later pass overwrites the continuing result.
// - The continuing result is first readable no later than 300 ms after the last host write.
// - Each stored continuing sum is compared with the first-pass sum and bit 0 of the diagnostic byte is updated.
// - The first comparison ends within 300 ms of the last write and later ones follow at most 150 ms apart.
// - Carries above 8 bits are dropped, so each result is the byte sum modulo 256.
// - The engine runs only while out of sleep and halts in sleep.
// - The accumulator is cleared to zero right after its value moves into a result.
// - Three host read commands return the first-pass sum, the continuing sum and the diagnostic byte.
// - After the first continuing pass the sum, store and compare cycle repeats without end.
package rcm_pkg;
	localparam int          CLK_HZ           = 40000000;
	localparam int          PASS_TIME_MS     = 150;
	localparam int          PASS_CYCLES_DEF  = (PASS_TIME_MS * (CLK_HZ / 1000));
	localparam int          SCAN_BYTES_DEF   = 1245184;
	localparam int          SCAN_AW          = 21;
	localparam int          DIV_W            = 32;
	localparam logic [7:0]  CMD_RD_FIRST     = 8'haa;
	localparam logic [7:0]  CMD_RD_CONT      = 8'haf;
	localparam logic [7:0]  CMD_RD_DIAG      = 8'h0f;
	localparam logic [7:0]  SUM_RESET        = 8'h00;
	localparam int          DIAG_MATCH_BIT   = 0;
	typedef enum logic [1:0] {
		RCM_IDLE,
		RCM_FIRST,
		RCM_RUN
	} rcm_state_t;
endpackage

// *** rtl/rcm_step_div.sv ***
// Step enable divider for the checksum scan
`timescale 1ns/100ps
module rcm_step_div
	import rcm_pkg::*;
#(
	parameter int DIV = 4
)
(
	// Clock and reset
	input  wire logic clk_sys_i,
	input  wire logic sys_rst_i,
	// Control
	input  wire logic restart_i,
	input  wire logic run_i,
	output logic      step_o
);
	localparam logic [DIV_W-1:0] LAST = DIV_W'(DIV - 1);
	logic [DIV_W-1:0] cnt_reg;

	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i || restart_i)
			cnt_reg <= '0;
		else if (run_i)
			cnt_reg <= (cnt_reg == LAST) ? '0 : cnt_reg + 1'b1;
	end

	assign step_o = run_i && !restart_i && (cnt_reg == LAST);
endmodule

// *** verification/rcm_monitor_properties.sv ***
// Port checker of the register checksum monitor
`timescale 1ns/100ps
module rcm_monitor_checker
#(
	parameter int SB = 8
)
(
	input wire logic        clk_sys_i,
	input wire logic        sys_rst_i,
	input wire logic        cmd_wr_i,
	input wire logic        cmd_rd_i,
	input wire logic [7:0]  cmd_code_i,
	input wire logic [7:0]  rd_data_o,
	input wire logic        rd_valid_o,
	input wire logic        sleep_out_i,
	input wire logic [20:0] scan_addr_o,
	input wire logic        scan_en_o,
	input wire logic [7:0]  first_pass_sum_o,
	input wire logic [7:0]  running_pass_sum_o,
	input wire logic        sum_match_flag_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i);
	a_read_answer: assert property (cmd_rd_i |=> rd_valid_o)
		else $error("read not answered");
	a_no_stray: assert property (!cmd_rd_i |=> !rd_valid_o)
		else $error("stray read answer");
	a_first_read: assert property (cmd_rd_i && cmd_code_i == 8'haa
		|=> rd_data_o == $past(first_pass_sum_o)) else $error("bad first");
	a_diag_read: assert property (cmd_rd_i && cmd_code_i == 8'h0f
		|=> rd_data_o == {7'h0, $past(sum_match_flag_o)})
		else $error("bad diag");
	a_write_clear: assert property (cmd_wr_i |=> !sum_match_flag_o &&
		first_pass_sum_o == 0 && running_pass_sum_o == 0) else $error("no clear");
	a_sleep_halt: assert property (!sleep_out_i |-> !scan_en_o)
		else $error("scan in sleep");
	a_match_eq: assert property (sum_match_flag_o |->
		first_pass_sum_o == running_pass_sum_o) else $error("bad flag");
	a_scan_order: assert property (scan_en_o && !cmd_wr_i |=> scan_addr_o ==
		($past(scan_addr_o) == SB - 1 ? 21'h0 : $past(scan_addr_o) + 21'h1))
		else $error("scan order broken");
endmodule

// *** verification/rcm_scan_mem.sv ***
// Byte store seen by the checksum scan
`timescale 1ns/100ps
module rcm_scan_mem
(
	// Scan port
	input  wire logic [20:0] addr_i,
	input  wire logic        alter_i,
	output logic      [7:0]  data_o
);
	// Modulo-256 sum of these eight bytes is e4
	logic [7:0] rom [8] = '{8'ha1, 8'h12, 8'h81, 8'hde,
		8'hf2, 8'h40, 8'h80, 8'h20};
	// Byte 0 bumped by one while alter_i is high
	always_comb data_o = rom[addr_i[2:0]] + {7'h0, alter_i && addr_i == 21'h0};
endmodule

// *** verification/tb.sv ***
// Self-checking bench of the register checksum monitor
`timescale 1ns/100ps
module tb;
	logic        clk_sys_i = 0, sys_rst_i = 1, cmd_wr_i = 0, cmd_rd_i = 0;
	logic        sleep_out_i = 1, alter = 0, rd_valid_o, scan_en_o;
	logic        sum_match_flag_o;
	logic [7:0]  cmd_code_i = 8'h00, rd_data_o, scan_data_i;
	logic [7:0]  first_pass_sum_o, running_pass_sum_o;
	logic [20:0] scan_addr_o;
	int          checks = 0, failures = 0, cyc = 0;
	rcm_monitor #(
		.PASS_CYCLES        (40),
		.SCAN_BYTES         (8)
	) dut_u (
		.clk_sys_i          (clk_sys_i),
		.sys_rst_i          (sys_rst_i),
		.cmd_wr_i           (cmd_wr_i),
		.cmd_rd_i           (cmd_rd_i),
		.cmd_code_i         (cmd_code_i),
		.rd_data_o          (rd_data_o),
		.rd_valid_o         (rd_valid_o),
		.sleep_out_i        (sleep_out_i),
		.scan_addr_o        (scan_addr_o),
		.scan_data_i        (scan_data_i),
		.scan_en_o          (scan_en_o),
		.first_pass_sum_o   (first_pass_sum_o),
		.running_pass_sum_o (running_pass_sum_o),
		.sum_match_flag_o   (sum_match_flag_o)
	);
	rcm_scan_mem mem_u (
		.addr_i  (scan_addr_o),
		.alter_i (alter),
		.data_o  (scan_data_i)
	);
	initial forever #12.5 clk_sys_i = ~clk_sys_i;
	task automatic chk(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		checks++;
		if (g !== e)
		begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic rd(input logic [7:0] code, input logic [7:0] e);
		@(posedge clk_sys_i);
		cmd_rd_i <= 1;
		cmd_code_i <= code;
		@(posedge clk_sys_i);
		cmd_rd_i <= 0;
		#1;
		chk("valid", 8'h01, {7'h0, rd_valid_o});
		chk("data", e, rd_data_o);
	endtask
	task automatic wr();
		@(posedge clk_sys_i) cmd_wr_i <= 1;
		@(posedge clk_sys_i) cmd_wr_i <= 0;
	endtask
	task automatic results();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	always @(posedge clk_sys_i)
	begin
		cyc++;
		if (cyc == 2000)
		begin
			failures++;
			results();
		end
	end
	initial
	begin
		repeat (12) @(posedge clk_sys_i);
		sys_rst_i <= 0;
		rd(8'haa, 8'h00);
		rd(8'h0f, 8'h00);
		repeat (45) @(posedge clk_sys_i);
		rd(8'haa, 8'h00);
		wr();
		rd(8'haf, 8'h00);
		repeat (45) @(posedge clk_sys_i);
		rd(8'haa, 8'he4);
		rd(8'haf, 8'h00);
		repeat (40) @(posedge clk_sys_i);
		rd(8'haf, 8'he4);
		rd(8'h0f, 8'h01);
		rd(8'haf, 8'he4);
		$display("test passes done");
		@(posedge clk_sys_i) alter <= 1;
		repeat (80) @(posedge clk_sys_i);
		rd(8'haf, 8'he5);
		rd(8'h0f, 8'h00);
		rd(8'haa, 8'he4);
		$display("test change done");
		wr();
		repeat (20) @(posedge clk_sys_i);
		wr();
		repeat (30) @(posedge clk_sys_i);
		rd(8'haa, 8'h00);
		repeat (15) @(posedge clk_sys_i);
		rd(8'haa, 8'he5);
		$display("test restart done");
		wr();
		@(posedge clk_sys_i) sleep_out_i <= 0;
		repeat (60) @(posedge clk_sys_i);
		rd(8'haa, 8'h00);
		rd(8'h55, 8'h00);
		@(posedge clk_sys_i) sleep_out_i <= 1;
		repeat (45) @(posedge clk_sys_i);
		rd(8'haa, 8'he5);
		$display("test sleep done");
		results();
	end
endmodule
bind rcm_monitor rcm_monitor_checker #(
	.SB                 (SCAN_BYTES)
) chk_u (
	.clk_sys_i          (clk_sys_i),
	.sys_rst_i          (sys_rst_i),
	.cmd_wr_i           (cmd_wr_i),
	.cmd_rd_i           (cmd_rd_i),
	.cmd_code_i         (cmd_code_i),
	.rd_data_o          (rd_data_o),
	.rd_valid_o         (rd_valid_o),
	.sleep_out_i        (sleep_out_i),
	.scan_addr_o        (scan_addr_o),
	.scan_en_o          (scan_en_o),
	.first_pass_sum_o   (first_pass_sum_o),
	.running_pass_sum_o (running_pass_sum_o),
	.sum_match_flag_o   (sum_match_flag_o)
);
